// [dsi_init_and_status_response_bench.sv]
// Self-checking bench for the init and status command handler.
`default_nettype none
module dsi_init_and_status_response_bench
  import dsiis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, rerr;
  logic cmdValid, cmdCrcOk, rspValid, rspLong, busTestDone, busFaultDet;
  logic reserveUnderVolt, internalError, diagCircuitOn, busTestStart;
  logic busSwitchClose, otpWriteEnable;
  logic [1:0]  cmdFormat, bankSelect;
  logic [3:0]  cmdCode, cmdAddress, cmdCrcBits, rspCrcBits, nodeAddress;
  logic [5:0]  cmdLength, rspLength;
  logic [7:0]  paddr, cmdData;
  logic [15:0] rspData;
  logic [31:0] pwdata, prdata, rdat;
  int          err_count, samples_checked;
  dsiis_top dut (.*);
  dsiis_cmd_master m (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
      err_count++;
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic expectOut(input logic r, s);
    #1;
    check("rspValid", rspValid, r);
    check("busTestStart", busTestStart, s);
  endtask
  task automatic doInit(input logic [3:0] a, input logic [7:0] d, input logic f);
    int n;
    n = 0;
    m.sendInit(a, d, 1'b1);
    expectOut(1'b0, 1'b1);
    @(posedge core_clk);
    {busFaultDet, busTestDone} <= {f, 1'b1};
    while (rspValid !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("init rsp", rspValid, 1'b1);
    @(posedge core_clk);
    busTestDone <= 1'b0;
  endtask
  task automatic results;
    $display("Comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    results();
  end
  initial
  begin
    {rst_n, ce, psel, penable, pwrite, paddr, pwdata} = {2'b01, 43'h0};
    {busTestDone, busFaultDet, reserveUnderVolt, internalError, diagCircuitOn} = 5'h00;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b1, OFS_DEV_CFG1, 32'h0000_0002);
    apb(1'b0, OFS_DEV_CFG1, 32'h0000_0000);
    check("tag reg", rdat, 32'h0000_0002);
    apb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped data", rdat, 32'h0000_0000);
    check("unmapped err", {31'h0000_0000, rerr}, 32'h0000_0001);
    m.send(FMT_STD_SHORT, CMD_STATUS, 4'h0, 8'h00, 1'b1, 6'h0C, 4'h2);
    expectOut(1'b0, 1'b0);
    m.sendInit(4'h0, 8'hC0, 1'b1);
    expectOut(1'b0, 1'b0);
    m.sendInit(4'h0, 8'hEA, 1'b1);
    expectOut(1'b0, 1'b0);
    m.send(FMT_STD_SHORT, CMD_INIT, 4'h0, 8'hDA, 1'b1, 6'h0C, 4'h4);
    expectOut(1'b0, 1'b0);
    m.sendInit(4'h0, 8'hDA, 1'b0);
    expectOut(1'b0, 1'b0);
    m.sendInit(4'h5, 8'hDA, 1'b1);
    expectOut(1'b0, 1'b0);
    doInit(4'h0, 8'hDA, 1'b0);
    check("init word", rspData, 16'hA0DA);
    check("switch", {busSwitchClose, bankSelect}, 3'b101);
    check("init frame", {rspLength, rspCrcBits}, {6'h14, 4'h4});
    check("node out", {otpWriteEnable, nodeAddress}, 5'h1A);
    m.sendInit(4'hA, 8'hDA, 1'b1);
    expectOut(1'b0, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check("status reg", rdat, 32'h0000_12BA);
    $display("init tests done");
    for (int i = 0; i < 4; i++)
    begin
      {reserveUnderVolt, diagCircuitOn, internalError} <= {~i[1], i[1], i[0]};
      repeat (4) @(posedge core_clk);
      m.send(2'(i), CMD_STATUS, 4'hA, 8'(i * 37), 1'b1, 6'(12 + i), 4'(i * 2 + 2));
      expectOut(1'b1, 1'b0);
      check("status word", rspData, {i[0] ? 4'h0 : 4'hA, 4'h0, 1'b1, ~i[1], i[1], 1'b1,
            2'b10, i[0], 1'b0});
      check("status frame", {rspLong, rspLength, rspCrcBits}, {~i[0], 6'(12 + i), 4'(i * 2 + 2)});
    end
    m.send(FMT_STD_SHORT, CMD_STATUS, 4'h5, 8'h00, 1'b1, 6'h0C, 4'h2);
    expectOut(1'b0, 1'b0);
    m.send(FMT_STD_LONG, CMD_STATUS, 4'hA, 8'h00, 1'b0, 6'h14, 4'h4);
    expectOut(1'b0, 1'b0);
    m.send(FMT_STD_LONG, 4'h2, 4'hA, 8'h00, 1'b1, 6'h14, 4'h4);
    expectOut(1'b0, 1'b0);
    // A request while the clock enable is low is not taken.
    ce <= 1'b0;
    m.send(FMT_STD_SHORT, CMD_STATUS, 4'hA, 8'h00, 1'b1, 6'h0C, 4'h2);
    expectOut(1'b0, 1'b0);
    check("pready frozen", pready, 1'b0);
    @(posedge core_clk);
    ce <= 1'b1;
    apb(1'b0, OFS_RSP_COUNT, 32'h0000_0000);
    check("rsp count", rdat, 32'h0000_0005);
    $display("status tests done");
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b1, OFS_ADDR_CFG, 32'h0000_0013);
    doInit(4'h3, 8'h43, 1'b1);
    check("fault word", rspData, 16'h3103);
    check("switch open", busSwitchClose, 1'b0);
    $display("preprogrammed test done");
    results();
  end
endmodule
`default_nettype wire

// [dsiis_checker.sv]
// Concurrent checks on the command and response ports of the handler.
`default_nettype none
module dsiis_checker
  import dsiis_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        cmdValid,
  input wire logic        cmdCrcOk,
  input wire logic [1:0]  cmdFormat,
  input wire logic [3:0]  cmdCode,
  input wire logic [3:0]  cmdAddress,
  input wire logic [7:0]  cmdData,
  input wire logic [5:0]  cmdLength,
  input wire logic [3:0]  cmdCrcBits,
  input wire logic        rspValid,
  input wire logic [15:0] rspData,
  input wire logic        rspLong,
  input wire logic [5:0]  rspLength,
  input wire logic [3:0]  rspCrcBits,
  input wire logic        internalError,
  input wire logic        diagCircuitOn,
  input wire logic        busTestStart,
  input wire logic        busSwitchClose,
  input wire logic        otpWriteEnable,
  input wire logic [1:0]  bankSelect,
  input wire logic [3:0]  nodeAddress
);
  timeunit 1ns;
  timeprecision 1ns;
  logic answered;
  // Set once the initialization answer has gone out.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      answered <= 1'b0;
    else if (rspValid)
      answered <= 1'b1;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence statusHit;
    answered && cmdValid && ce && cmdCrcOk && cmdCode == CMD_STATUS
      && cmdAddress == nodeAddress && nodeAddress != ADDR_GLOBAL;
  endsequence
  sequence initTry;
    !answered && cmdValid && ce && cmdCode == CMD_INIT;
  endsequence
  status_answer_a: assert property (statusHit |=> rspValid && rspLength == $past(cmdLength)
    && rspCrcBits == $past(cmdCrcBits)) else $error("status request not answered");
  status_fields_a: assert property (statusHit |=> rspData[11:8] == 4'h0 && !rspData[0]
    && rspData[7] == otpWriteEnable && rspData[4] == busSwitchClose
    && rspData[1] == $past(internalError) && rspData[5] == $past(diagCircuitOn))
    else $error("status word fields wrong");
  status_shape_a: assert property (statusHit |=> rspLong == ~|($past(cmdFormat) & 2'b01)
    && rspData[15:12] == (rspLong ? nodeAddress : 4'h0)) else $error("status layout wrong");
  status_ignored_a: assert property (answered && cmdValid
    && (cmdAddress != nodeAddress || !cmdCrcOk) |=> !rspValid) else $error("status not ignored");
  init_reject_a: assert property (initTry ##0 (cmdFormat != FMT_STD_LONG || !cmdCrcOk
    || cmdData[3:0] == 4'h0 || cmdData[5]) |=> !busTestStart) else $error("bad init taken");
  init_once_a: assert property (answered && cmdValid && cmdCode == CMD_INIT
    |=> !busTestStart && $stable(nodeAddress)) else $error("second init taken");
  init_word_a: assert property (rspValid && !answered |-> rspData[15:12] == nodeAddress
    && rspData[3:0] == nodeAddress && rspData[11:9] == 3'h0 && rspCrcBits == INIT_CRC_BITS
    && rspData[7:4] == {otpWriteEnable, busSwitchClose, bankSelect}) else $error("init word wrong");
  fault_open_a: assert property (rspValid && !answered && rspData[8] |-> !busSwitchClose)
    else $error("switch closed on fault");
  test_first_a: assert property (busTestStart |=> !rspValid [*3])
    else $error("init answer before bus test");
  addr_assign_a: assert property (busTestStart |-> {4'h0, nodeAddress} == ($past(cmdData) & 8'h0F))
    else $error("node address not assigned");
endmodule
bind dsiis_top dsiis_checker chk (.*);
`default_nettype wire

// [dsiis_cmd_master.sv]
// Command side of the bus master that addresses the handler.
`default_nettype none
module dsiis_cmd_master
  import dsiis_pkg::*;
(
  input  wire logic       core_clk,
  output logic            cmdValid,
  output logic            cmdCrcOk,
  output logic [1:0]      cmdFormat,
  output logic [3:0]      cmdCode,
  output logic [3:0]      cmdAddress,
  output logic [7:0]      cmdData,
  output logic [5:0]      cmdLength,
  output logic [3:0]      cmdCrcBits
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {cmdValid, cmdCrcOk, cmdFormat, cmdCode, cmdAddress, cmdData, cmdLength, cmdCrcBits} = '0;
  end
  // Presents one decoded frame for one cycle, then inverts the idle address, data and code fields.
  task automatic send(input logic [1:0] f, input logic [3:0] c, a, input logic [7:0] d,
                      input logic ok, input logic [5:0] n, input logic [3:0] k);
    @(posedge core_clk);
    {cmdValid, cmdCrcOk, cmdFormat, cmdCode} <= {1'b1, ok, f, c};
    {cmdAddress, cmdData, cmdLength, cmdCrcBits} <= {a, d, n, k};
    @(posedge core_clk);
    cmdValid <= 1'b0;
    {cmdAddress, cmdData, cmdCode} <= ~{a, d, c};
  endtask
  // Initialization always goes out as a standard long frame.
  task automatic sendInit(input logic [3:0] a, input logic [7:0] d, input logic ok);
    send(FMT_STD_LONG, CMD_INIT, a, d, ok, 6'h14, 4'h4);
  endtask
endmodule
`default_nettype wire

// [dsiis_pkg.sv]
// Shared constants and types for the DSI init and status command block.
`default_nettype none
package dsiis_pkg;
  // Command codes in the command nibble, and the global node address.
  localparam logic [3:0] CMD_INIT   = 4'h0;
  localparam logic [3:0] CMD_STATUS = 4'h1;
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;
  // Command formats.
  typedef enum logic [1:0] {
    FMT_STD_LONG  = 2'b00,
    FMT_STD_SHORT = 2'b01,
    FMT_ENH_LONG  = 2'b10,
    FMT_ENH_SHORT = 2'b11
  } dsiis_fmt_t;
  // Initialization data byte fields.
  localparam int INI_OTP  = 7;
  localparam int INI_BSW  = 6;
  localparam int INI_BNKH = 5;
  localparam int INI_BNKL = 4;
  // Banks that an initialization may select, one bit per code.
  localparam logic [3:0] BANK_VALID = 4'h3;
  // Response CRC length of the initialization response.
  localparam logic [3:0] INIT_CRC_BITS = 4'h4;
  // Control states, Gray along init, test, answer, ready.
  typedef enum logic [1:0] {
    ST_UNINIT = 2'b00,
    ST_TEST   = 2'b01,
    ST_RESP   = 2'b11,
    ST_READY  = 2'b10
  } dsiis_state_t;
  // Synchroniser bit positions.
  localparam int SY_DONE  = 0;
  localparam int SY_FAULT = 1;
  localparam int SY_UV    = 2;
  // APB register byte offsets.
  localparam logic [7:0] OFS_ADDR_CFG  = 8'h00;
  localparam logic [7:0] OFS_DEV_CFG1  = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_RSP_COUNT = 8'h0C;
  // Address config fields.
  localparam int CFG_PROG_VALID = 4;
  // Status register fields.
  localparam int STA_INIT  = 4;
  localparam int STA_BSW   = 5;
  localparam int STA_FAULT = 6;
  localparam int STA_BANK  = 7;
  localparam int STA_OTP   = 9;
  localparam int STA_UV    = 10;
  localparam int STA_STATE = 11;
  // Reset values.
  localparam logic [3:0] RST_PROG_ADDR = 4'h0;
  localparam logic [1:0] RST_TAG_BITS  = 2'h0;
endpackage
`default_nettype wire

// [dsiis_rsp_fmt.sv]
// Response word builder for initialization and status answers.
`default_nettype none
module dsiis_rsp_fmt
  import dsiis_pkg::*;
(
  dsiis_rsp_if.fmt rsp
);
  logic [7:0] lowByte;

  always_comb
  begin
    lowByte = {rsp.otpWriteEnable, rsp.underVolt, rsp.diagCircuitOn, rsp.busSwitch,
               rsp.userTagBits, rsp.intError, 1'b0};
    if (rsp.isInit)
    begin
      rsp.word = {rsp.nodeAddress, 3'b000, rsp.busFaultFlag, rsp.otpWriteEnable,
                  rsp.busSwitch, rsp.bankSel, rsp.nodeAddress};
    end
    else if (rsp.isLong)
    begin
      rsp.word = {rsp.nodeAddress, 4'h0, lowByte};
    end
    else
    begin
      rsp.word = {8'h00, lowByte};
    end
  end
endmodule
`default_nettype wire

// [dsiis_rsp_if.sv]
// Interface carrying response fields to the response word builder.
`default_nettype none
interface dsiis_rsp_if;
  logic [3:0]  nodeAddress;
  logic        otpWriteEnable;
  logic        underVolt;
  logic        diagCircuitOn;
  logic        busSwitch;
  logic [1:0]  userTagBits;
  logic        intError;
  logic        busFaultFlag;
  logic [1:0]  bankSel;
  logic        isInit;
  logic        isLong;
  logic [15:0] word;
  modport core (output nodeAddress, otpWriteEnable, underVolt, diagCircuitOn, busSwitch,
                output userTagBits, intError, busFaultFlag, bankSel, isInit, isLong,
                input word);
  modport fmt (input nodeAddress, otpWriteEnable, underVolt, diagCircuitOn, busSwitch,
               input userTagBits, intError, busFaultFlag, bankSel, isInit, isLong,
               output word);
endinterface
`default_nettype wire

// [dsiis_top.sv]
// Command handler for DSI initialization and status request, with APB registers.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module dsiis_top
  import dsiis_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmdValid,
  input  wire logic        cmdCrcOk,
  input  wire logic [1:0]  cmdFormat,
  input  wire logic [3:0]  cmdCode,
  input  wire logic [3:0]  cmdAddress,
  input  wire logic [7:0]  cmdData,
  input  wire logic [5:0]  cmdLength,
  input  wire logic [3:0]  cmdCrcBits,
  output logic             rspValid,
  output logic [15:0]      rspData,
  output logic             rspLong,
  output logic [5:0]       rspLength,
  output logic [3:0]       rspCrcBits,
  input  wire logic        busTestDone,
  input  wire logic        busFaultDet,
  input  wire logic        reserveUnderVolt,
  input  wire logic        internalError,
  input  wire logic        diagCircuitOn,
  output logic             busTestStart,
  output logic             busSwitchClose,
  output logic             otpWriteEnable,
  output logic [1:0]       bankSelect,
  output logic [3:0]       nodeAddress
);

  typedef struct packed {
    dsiis_state_t state;
    logic [3:0]   progAddr;
    logic         progValid;
    logic [1:0]   userTagBits;
    logic [3:0]   nodeAddr;
    logic         otpEn;
    logic         busReq;
    logic         busSw;
    logic         busFault;
    logic [1:0]   bank;
    logic [2:0]   syncMeta;
    logic [2:0]   syncLvl;
    logic         testStart;
    logic         rspValid;
    logic [15:0]  rspData;
    logic         rspLong;
    logic [5:0]   rspLen;
    logic [3:0]   rspCrc;
    logic [5:0]   pendLen;
    logic [15:0]  rspCount;
    logic [31:0]  prdata;
    logic         pslverr;
  } dsiis_regs_t;

  dsiis_regs_t st_ff;
  dsiis_regs_t nxt_st;

  dsiis_rsp_if rspIf ();

  logic        cmdGood;
  logic        isLongFmt;
  logic [3:0]  initAddrExp;
  logic        initAddrOk;
  logic        initAccept;
  logic        statusAccept;
  logic        apbSetup;
  logic        apbWrite;
  logic [31:0] rdValue;
  logic        rdHit;

  ////////////////////////////////////////////////////////////////////////////////
  // Response word builder and its field feed.

  dsiis_rsp_fmt u_fmt (
    .rsp (rspIf.fmt)
  );

  assign rspIf.nodeAddress    = st_ff.nodeAddr;
  assign rspIf.otpWriteEnable = st_ff.otpEn;
  assign rspIf.underVolt      = st_ff.syncLvl[SY_UV];
  assign rspIf.diagCircuitOn  = diagCircuitOn;
  assign rspIf.busSwitch      = st_ff.busSw;
  assign rspIf.userTagBits    = st_ff.userTagBits;
  assign rspIf.intError       = internalError;
  assign rspIf.busFaultFlag   = st_ff.busFault;
  assign rspIf.bankSel        = st_ff.bank;
  assign rspIf.isInit         = (st_ff.state == ST_RESP);
  assign rspIf.isLong         = isLongFmt;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode.

  // The data byte of a status request is never looked at beyond the CRC verdict.
  assign cmdGood   = cmdValid & cmdCrcOk;
  assign isLongFmt = (cmdFormat == FMT_STD_LONG) | (cmdFormat == FMT_ENH_LONG);

  // Expected command address: programmed address, else the global address.
  assign initAddrExp = st_ff.progValid ? st_ff.progAddr : ADDR_GLOBAL;

  always_comb
  begin
    initAddrOk = (cmdAddress == initAddrExp);
    if (st_ff.progValid && (cmdData[3:0] != st_ff.progAddr))
    begin
      initAddrOk = 1'b0;
    end
  end

  assign initAccept = cmdGood
                    & (st_ff.state == ST_UNINIT)
                    & (cmdCode == CMD_INIT)
                    & (cmdFormat == FMT_STD_LONG)
                    & initAddrOk
                    & (cmdData[3:0] != ADDR_GLOBAL)
                    & BANK_VALID[cmdData[INI_BNKH:INI_BNKL]];

  assign statusAccept = cmdGood
                      & (st_ff.state == ST_READY)
                      & (cmdCode == CMD_STATUS)
                      & (st_ff.nodeAddr != ADDR_GLOBAL)
                      & (cmdAddress == st_ff.nodeAddr);

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode.

  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;

  always_comb
  begin
    rdValue = 32'h0000_0000;
    rdHit   = 1'b1;
    unique case (paddr)
      OFS_ADDR_CFG:
      begin
        rdValue[3:0]           = st_ff.progAddr;
        rdValue[CFG_PROG_VALID] = st_ff.progValid;
      end
      OFS_DEV_CFG1:
      begin
        rdValue[1:0] = st_ff.userTagBits;
      end
      OFS_STATUS:
      begin
        rdValue[3:0]                 = st_ff.nodeAddr;
        rdValue[STA_INIT]            = (st_ff.state != ST_UNINIT);
        rdValue[STA_BSW]             = st_ff.busSw;
        rdValue[STA_FAULT]           = st_ff.busFault;
        rdValue[STA_BANK +: 2]       = st_ff.bank;
        rdValue[STA_OTP]             = st_ff.otpEn;
        rdValue[STA_UV]              = st_ff.syncLvl[SY_UV];
        rdValue[STA_STATE +: 2]      = st_ff.state;
      end
      OFS_RSP_COUNT:
      begin
        rdValue[15:0] = st_ff.rspCount;
      end
      default:
      begin
        rdHit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.testStart = 1'b0;
    nxt_st.rspValid  = 1'b0;

    // Bus test, fault and undervoltage pin levels pass two flip-flops before use.
    nxt_st.syncMeta = {reserveUnderVolt, busFaultDet, busTestDone};
    nxt_st.syncLvl  = st_ff.syncMeta;

    // Register access; read data and error are captured in the setup cycle.
    if (apbSetup)
    begin
      nxt_st.prdata  = rdValue;
      nxt_st.pslverr = ~rdHit;
    end
    if (apbWrite)
    begin
      if (paddr == OFS_ADDR_CFG)
      begin
        nxt_st.progAddr  = pwdata[3:0];
        nxt_st.progValid = pwdata[CFG_PROG_VALID];
      end
      else if (paddr == OFS_DEV_CFG1)
      begin
        nxt_st.userTagBits = pwdata[1:0];
      end
    end

    unique case (st_ff.state)
      ST_UNINIT:
      begin
        if (initAccept)
        begin
          nxt_st.nodeAddr  = cmdData[3:0];
          nxt_st.otpEn     = cmdData[INI_OTP];
          nxt_st.busReq    = cmdData[INI_BSW];
          nxt_st.bank      = cmdData[INI_BNKH:INI_BNKL];
          nxt_st.busSw     = 1'b0;
          nxt_st.busFault  = 1'b0;
          nxt_st.pendLen   = cmdLength;
          nxt_st.testStart = 1'b1;
          nxt_st.state     = ST_TEST;
        end
      end
      ST_TEST:
      begin
        if (st_ff.syncLvl[SY_DONE])
        begin
          nxt_st.busFault = st_ff.syncLvl[SY_FAULT];
          nxt_st.busSw    = st_ff.busReq & ~st_ff.syncLvl[SY_FAULT];
          nxt_st.state    = ST_RESP;
        end
      end
      ST_RESP:
      begin
        nxt_st.rspValid = 1'b1;
        nxt_st.rspData  = rspIf.word;
        nxt_st.rspLong  = 1'b1;
        nxt_st.rspLen   = st_ff.pendLen;
        nxt_st.rspCrc   = INIT_CRC_BITS;
        nxt_st.rspCount = st_ff.rspCount + 16'h0001;
        nxt_st.state    = ST_READY;
      end
      ST_READY:
      begin
        if (statusAccept)
        begin
          nxt_st.rspValid = 1'b1;
          nxt_st.rspData  = rspIf.word;
          nxt_st.rspLong  = isLongFmt;
          nxt_st.rspLen   = cmdLength;
          nxt_st.rspCrc   = cmdCrcBits;
          nxt_st.rspCount = st_ff.rspCount + 16'h0001;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_ff             <= '0;
      st_ff.state       <= ST_UNINIT;
      st_ff.progAddr    <= RST_PROG_ADDR;
      st_ff.userTagBits <= RST_TAG_BITS;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata         = st_ff.prdata;
  assign pready         = ce;
  assign pslverr        = st_ff.pslverr;
  assign rspValid       = st_ff.rspValid;
  assign rspData        = st_ff.rspData;
  assign rspLong        = st_ff.rspLong;
  assign rspLength      = st_ff.rspLen;
  assign rspCrcBits     = st_ff.rspCrc;
  assign busTestStart   = st_ff.testStart;
  assign busSwitchClose = st_ff.busSw;
  assign otpWriteEnable = st_ff.otpEn;
  assign bankSelect     = st_ff.bank;
  assign nodeAddress    = st_ff.nodeAddr;

endmodule
`default_nettype wire
